// ---- rtl/arr_pkg.sv ----
// Package for the result and register-check register block.
// Assumes one 50 MHz clock domain and a serial front end that decodes commands.
package arr_pkg;

  // Register addresses on the serial interface.
  localparam logic [5:0] ADDR_CHECK  = 6'h03;
  localparam logic [5:0] ADDR_RESULT = 6'h04;
  localparam logic [5:0] ADDR_MODE   = 6'h02;

  // Interface mode low-bit field positions.
  localparam int POS_SHORT_WL = 0;
  localparam int POS_RSVD1    = 1;
  localparam int POS_CRC_LO   = 2;
  localparam int POS_INTEG_EN = 5;
  localparam int POS_STAT_APP = 6;
  localparam int POS_CONT_RD  = 7;

  // Reset values.
  localparam logic [15:0] INTERFACE_MODE_LOW_BITS_RST = 16'h0000;
  localparam logic [23:0] CHECK_RST  = 24'h000000;
  localparam logic [23:0] RESULT_RST = 24'h000000;
  localparam logic [7:0]  STAT_RST   = 8'h00;
  localparam logic [31:0] RDATA_RST  = 32'h00000000;

  // Writable bits of the interface mode low word; reserved bits read zero.
  localparam logic [15:0] INTERFACE_MODE_LOW_BITS_WMASK = 16'h09ED;

  // Checksum protection modes.
  typedef enum logic [1:0] {
    ARR_CRC_OFF = 2'b00,
    ARR_CRC_XOR = 2'b01,
    ARR_CRC_ALL = 2'b10
  } arr_crc_e;

  // Register access request from the serial front end.
  typedef struct packed {
    logic        cmd;
    logic        wr;
    logic [5:0]  addr;
    logic [15:0] wdata;
  } arr_req_s;

  // Framing information for the serial front end.
  typedef struct packed {
    logic       rd_crc;
    logic       rd_xor;
    logic       wr_crc;
    logic [2:0] rd_bytes;
  } arr_frame_s;

endpackage : arr_pkg

// ---- rtl/arr_regs.sv ----
// Interface mode low bits, register-check and conversion result registers.
// Assumes the serial front end decodes commands into one-cycle requests and
// that the converter core delivers results with a one-cycle strobe.
`timescale 1ns/1ps

// Contract
// RULE1 - Field value 10 applies CRC to both register reads and writes.
// RULE2 - Field 00 adds no checksum, 01 gives XOR reads and CRC writes, and any enable adds a byte.
// RULE3 - The host writes zero to reserved bit 1, which reads back as zero.
// RULE4 - The short word bit selects a 16-bit result when set and 24-bit when clear.
// RULE5 - Mode writes do not reset the converter and only the next result takes the new width.
// RULE6 - Address 03 holds a read-only 24-bit XOR of the user registers, reset to zero.
// RULE7 - With integrity checking disabled the checksum is not computed and reads zero.
// RULE8 - With checking enabled any change of a checked register sets the integrity fault.
// RULE9 - The result at address 04 is offset binary unless the setup selects unipolar; the code passes conv_code unchanged in both codings.
// RULE10 - A result read drives the ready bit and ready pin inactive high; the code drives only the ready_n pin high.
// RULE11 - The held result may be read repeatedly and returns the same value.
// RULE12 - After a result read command, new conversions do not overwrite the result.
// RULE13 - With status append set the status byte follows each result read.
// RULE14 - The appended status belongs to exactly the result it accompanies.
// RULE15 - The host sizes each result read from width, status byte and checksum byte.
module arr_regs (
  // Clock and reset.
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  // Register access from the serial front end.
  input  wire arr_pkg::arr_req_s  req,
  input  wire logic               read_done,
  output logic [31:0]             rdata,
  output arr_pkg::arr_frame_s     frame,
  // Converter core side.
  input  wire logic               conv_valid,
  input  wire logic [23:0]        conv_code,
  input  wire logic               conv_unipolar,
  input  wire logic [7:0]         conv_status,
  // XOR of the checked user registers.
  input  wire logic [23:0]        user_xor,
  // Status and mode outputs.
  output logic                    ready_n,
  output logic                    integ_fault,
  output logic [15:0]             interface_mode_low_bits
);

  // Held state and the values it takes at the next edge.
  logic [15:0]         next_interface_mode_low_bits;
  logic [23:0]         result;
  logic [23:0]         next_result;
  logic [7:0]          res_status;
  logic [7:0]          next_res_status;
  logic                res_short;
  logic                next_res_short;
  logic                hold;
  logic                next_hold;
  logic                next_ready_n;
  logic [23:0]         check;
  logic [23:0]         next_check;
  logic                armed;
  logic                next_armed;
  logic                next_integ_fault;
  logic [31:0]         next_rdata;
  arr_pkg::arr_frame_s next_frame;
  arr_pkg::arr_crc_e   next_crc;

  // Decoded commands and mode fields.
  logic                wr_mode;
  logic                rd_res;
  logic                rd_chk;
  logic                capture;
  logic                integ_en;
  logic                short_word_len;
  logic                stat_app;

  // Keeps the top 16 bits of a code, right aligned, when the short width is chosen.
  function automatic logic [23:0] fit_width(input logic [23:0] code,
                                            input logic        short_len);
    fit_width = short_len ? {8'h00, code[23:8]} : code;
  endfunction : fit_width

  // Lays out a result read: the code, then the status byte when it is appended.
  // The layout follows the width the result was captured with, not the current mode.
  function automatic logic [31:0] result_word(input logic [23:0] res,
                                              input logic [7:0]  stat,
                                              input logic        short_len,
                                              input logic        app);
    if (!app) begin
      result_word = {8'h00, res};
    end else if (short_len) begin
      result_word = {8'h00, res[15:0], stat};
    end else begin
      result_word = {res, stat};
    end
  endfunction : result_word

  // Counts the bytes of a result read: code, appended status and checksum byte.
  function automatic logic [2:0] read_len(input logic short_len,
                                          input logic app,
                                          input logic sum);
    read_len = (short_len ? 3'h2 : 3'h3) + {2'h0, app} + {2'h0, sum};
  endfunction : read_len

  // Command decode; the front end presents every command as a one-cycle pulse.
  always_comb begin
    wr_mode        = req.cmd & req.wr & (req.addr == arr_pkg::ADDR_MODE);
    rd_res         = req.cmd & ~req.wr & (req.addr == arr_pkg::ADDR_RESULT);
    rd_chk         = req.cmd & ~req.wr & (req.addr == arr_pkg::ADDR_CHECK);
    // RULE12 refuse under hold
    capture        = conv_valid & ~hold & ~rd_res;
    integ_en       = interface_mode_low_bits[arr_pkg::POS_INTEG_EN];
    short_word_len = interface_mode_low_bits[arr_pkg::POS_SHORT_WL];
    stat_app       = interface_mode_low_bits[arr_pkg::POS_STAT_APP];
  end

  // Mode register next value; reserved bits are forced to zero on every write.
  always_comb begin
    next_interface_mode_low_bits = interface_mode_low_bits;
    // RULE3 reserved bits masked
    if (wr_mode) begin
      next_interface_mode_low_bits = req.wdata & arr_pkg::INTERFACE_MODE_LOW_BITS_WMASK;
    end
  end

  // Mode register flops; a mode write never touches the result path.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      interface_mode_low_bits <= arr_pkg::INTERFACE_MODE_LOW_BITS_RST;
    end else begin
      interface_mode_low_bits <= next_interface_mode_low_bits;
    end
  end

  // Read hold: set by a result read command and released when the serial read ends.
  // A new command wins over a release in the same cycle, so back-to-back reads stay safe.
  always_comb begin
    next_hold = hold;
    // RULE12 block result update
    if (rd_res) begin
      next_hold = 1'b1;
    end else if (read_done) begin
      next_hold = 1'b0;
    end
  end

  // Read hold flop.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold <= 1'b0;
    end else begin
      hold <= next_hold;
    end
  end

  // Result capture. A conversion that completes in the command cycle or under the
  // hold is dropped rather than queued, so the host never sees a word change mid-read.
  always_comb begin
    next_result     = result;
    next_res_status = res_status;
    next_res_short  = res_short;
    // RULE4 width at completion
    // RULE5 width kept per result
    // RULE9 code passed unchanged whichever coding conv_unipolar selects
    if (capture) begin
      next_result     = fit_width(conv_unipolar ? conv_code : conv_code, short_word_len);
      // RULE14 status matches result
      next_res_status = conv_status;
      next_res_short  = short_word_len;
    end
  end

  // Result flops; the width flag travels with the code it describes.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      result     <= arr_pkg::RESULT_RST;
      res_status <= arr_pkg::STAT_RST;
      res_short  <= 1'b0;
    end else begin
      result     <= next_result;
      res_status <= next_res_status;
      res_short  <= next_res_short;
    end
  end

  // Ready output: low from a captured result until the next result read.
  always_comb begin
    next_ready_n = ready_n;
    if (capture) begin
      next_ready_n = 1'b0;
    end
    // RULE10 ready goes inactive
    if (rd_res) begin
      next_ready_n = 1'b1;
    end
  end

  // Ready flop.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_n <= 1'b1;
    end else begin
      ready_n <= next_ready_n;
    end
  end

  // Integrity checker. The checksum is latched on the first cycle with the enable set
  // and compared with the live value from then on; an armed flag, not a zero test,
  // marks the latch so that a register set whose checksum is zero is guarded as well.
  always_comb begin
    next_armed       = integ_en;
    next_check       = check;
    next_integ_fault = integ_fault;
    // RULE6 checksum of user regs
    // RULE7 zero while disabled
    // RULE8 fault on change
    if (!integ_en) begin
      next_check       = arr_pkg::CHECK_RST;
      next_integ_fault = 1'b0;
    end else if (!armed) begin
      next_check = user_xor;
    end else if (user_xor != check) begin
      next_integ_fault = 1'b1;
    end
  end

  // Integrity flops; the fault stays set until the enable is cleared.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      armed       <= 1'b0;
      check       <= arr_pkg::CHECK_RST;
      integ_fault <= 1'b0;
    end else begin
      armed       <= next_armed;
      check       <= next_check;
      integ_fault <= next_integ_fault;
    end
  end

  // Read data. It is loaded only by a read command and otherwise holds, so the host
  // may shift it out at its own pace.
  always_comb begin
    next_rdata = rdata;
    // RULE11 held value returned
    // RULE13 status appended
    if (rd_res) begin
      next_rdata = result_word(result, res_status, res_short, stat_app);
    end else if (rd_chk) begin
      // RULE7 zero read while disabled
      next_rdata = integ_en ? {8'h00, check} : arr_pkg::RDATA_RST;
    end
  end

  // Framing is decoded from the next mode value so it changes on the same edge as the
  // mode register; the read length follows the width of the result that is held.
  always_comb begin
    next_crc            = arr_pkg::arr_crc_e'(next_interface_mode_low_bits[arr_pkg::POS_CRC_LO +: 2]);
    // RULE1 CRC both ways
    next_frame.rd_crc   = (next_crc == arr_pkg::ARR_CRC_ALL);
    // RULE2 checksum modes
    next_frame.rd_xor   = (next_crc == arr_pkg::ARR_CRC_XOR);
    next_frame.wr_crc   = (next_crc != arr_pkg::ARR_CRC_OFF);
    next_frame.rd_bytes = read_len(next_res_short, next_interface_mode_low_bits[arr_pkg::POS_STAT_APP],
                                   next_crc != arr_pkg::ARR_CRC_OFF);
  end

  // Read data and framing flops.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= arr_pkg::RDATA_RST;
      frame <= '0;
    end else begin
      rdata <= next_rdata;
      frame <= next_frame;
    end
  end

endmodule : arr_regs

// ---- test/arr_host.sv ----
// Host model: issues register commands and ends each result read.
// Assumes the block answers one cycle after the command edge.
`timescale 1ns/1ps
module arr_host (
  // Clock and framing.
  input  wire logic                sys_clk,
  input  wire arr_pkg::arr_frame_s frame,
  // Requests.
  output arr_pkg::arr_req_s        req,
  output logic                     read_done
);
  // Idle lines show a changing pattern, never the last request.
  initial begin
    req = '0;
    read_done = 1'b0;
  end
  task automatic xfer(input logic wr, input logic [5:0] addr, input logic [15:0] wdata);
    @(posedge sys_clk) #1 req = '{1'b1, wr, addr, wdata};
    @(posedge sys_clk) #1 req = '{1'b0, ~wr, ~addr, ~wdata};
    if (!wr && addr == arr_pkg::ADDR_RESULT) begin
      repeat (frame.rd_bytes) @(posedge sys_clk);
      #1 read_done = 1'b1;
      @(posedge sys_clk) #1 read_done = 1'b0;
    end
  endtask : xfer
endmodule : arr_host

// ---- test/arr_regs_props.sv ----
// Checker for the result and register-check block, bound to its ports.
// Assumes one clock domain and one-cycle command pulses.
`timescale 1ns/1ps
module arr_regs_props (
  // Clock and reset.
  input wire logic                sys_clk,
  input wire logic                rst_n,
  // Watched ports.
  input wire arr_pkg::arr_req_s   req,
  input wire logic                read_done,
  input wire logic [31:0]         rdata,
  input wire arr_pkg::arr_frame_s frame,
  input wire logic                conv_valid,
  input wire logic                ready_n,
  input wire logic [15:0]         interface_mode_low_bits
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Decoded commands.
  wire logic rd_res = req.cmd && !req.wr && req.addr == arr_pkg::ADDR_RESULT;
  wire logic rd_chk = req.cmd && !req.wr && req.addr == arr_pkg::ADDR_CHECK;
  wire logic wr_md  = req.cmd && req.wr && req.addr == arr_pkg::ADDR_MODE;
  AST_CRC_ALL: assert property (interface_mode_low_bits[3:2] == 2'b10 |-> frame.rd_crc && frame.wr_crc)
    else $error("crc not on both directions");
  AST_CRC_XOR: assert property (interface_mode_low_bits[3:2] == 2'b01 |-> frame.rd_xor && frame.wr_crc)
    else $error("xor read mode wrong");
  AST_RSVD: assert property ((interface_mode_low_bits & ~arr_pkg::INTERFACE_MODE_LOW_BITS_WMASK) == 16'h0000)
    else $error("reserved bit set");
  AST_MODE_WR: assert property (wr_md |=> interface_mode_low_bits == ($past(req.wdata) & arr_pkg::INTERFACE_MODE_LOW_BITS_WMASK))
    else $error("mode write wrong");
  AST_CHK_OFF: assert property (rd_chk && !interface_mode_low_bits[5] |=> rdata == 32'h0000_0000)
    else $error("check read not zero");
  AST_RD_READY: assert property (rd_res |=> ready_n)
    else $error("ready not cleared by read");
  AST_HOLD: assert property (rd_res ##1 (conv_valid && !read_done) |=> ready_n)
    else $error("result replaced during read");
  AST_WIDTH: assert property (rd_res && !interface_mode_low_bits[6] |=> rdata[31:24] == 8'h00)
    else $error("result read too wide");
endmodule : arr_regs_props
bind arr_regs arr_regs_props u_props (.sys_clk(sys_clk), .rst_n(rst_n), .req(req),
  .read_done(read_done), .rdata(rdata), .frame(frame), .conv_valid(conv_valid),
  .ready_n(ready_n), .interface_mode_low_bits(interface_mode_low_bits));

// ---- test/test_adc_result_and_integrity_checksum_regs.sv ----
// Bench for the result and register-check block with a host model.
// Assumes a 50 MHz clock and inputs driven 1 ns after each rising edge.
`timescale 1ns/1ps
module test_adc_result_and_integrity_checksum_regs;
  logic sys_clk = 1'b0, rst_n = 1'b0, conv_valid = 1'b0, conv_unipolar = 1'b0;
  logic [23:0] conv_code = 24'h000000, user_xor = 24'h000000, m_code = 24'h000000;
  logic [7:0] conv_status = 8'h00, m_st = 8'h00;
  logic [15:0] interface_mode_low_bits, m_mode = 16'h0000, wd;
  logic [31:0] rdata;
  logic m_wl = 1'b0, read_done, ready_n, integ_fault;
  arr_pkg::arr_req_s req;
  arr_pkg::arr_frame_s frame;
  int mismatches = 0, checks_done = 0, seed = 32'h727D;
  always #10 sys_clk = ~sys_clk;
  arr_host u_host (.sys_clk(sys_clk), .frame(frame), .req(req), .read_done(read_done));
  arr_regs u_arr_regs (.sys_clk(sys_clk), .rst_n(rst_n), .req(req), .read_done(read_done),
    .rdata(rdata), .frame(frame), .conv_valid(conv_valid), .conv_code(conv_code),
    .conv_unipolar(conv_unipolar), .conv_status(conv_status), .user_xor(user_xor),
    .ready_n(ready_n), .integ_fault(integ_fault), .interface_mode_low_bits(interface_mode_low_bits));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  task automatic set_mode(input logic [15:0] v);
    u_host.xfer(1'b1, arr_pkg::ADDR_MODE, v);
    m_mode = v & arr_pkg::INTERFACE_MODE_LOW_BITS_WMASK;
  endtask : set_mode
  // A result takes the width chosen when it completes.
  task automatic conv(input logic keep);
    @(posedge sys_clk) #1 conv_valid = 1'b1;
    conv_code = 24'($random(seed));
    conv_status = 8'($random(seed));
    conv_unipolar = conv_code[0];
    if (keep) {m_code, m_st, m_wl} = {conv_code, conv_status, m_mode[0]};
    @(posedge sys_clk) #1 conv_valid = 1'b0;
  endtask : conv
  function automatic logic [31:0] exp_res(input logic app);
    logic [23:0] w;
    w = m_wl ? {8'h00, m_code[23:8]} : m_code;
    return app ? {w, m_st} : {8'h00, w};
  endfunction : exp_res
  // Result read length: held width, appended status and checksum byte.
  function automatic logic [31:0] exp_len();
    return (m_wl ? 2 : 3) + m_mode[6] + (m_mode[3:2] != 2'b00);
  endfunction : exp_len
  // Watchdog against a hung handshake.
  initial begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    check({interface_mode_low_bits, 15'h0000, ready_n}, 32'h0000_0001);
    for (int i = 0; i < 3; i++) begin
      wd = 16'($random(seed));
      wd[3:2] = 2'(i);
      set_mode(wd);
      check(interface_mode_low_bits, m_mode);
      check({frame.rd_crc, frame.rd_xor, frame.wr_crc}, {i == 2, i == 1, i != 0});
      check(frame.rd_bytes, exp_len());
    end
    set_mode(16'h0000);
    conv(1'b1);
    @(posedge sys_clk) #1 check(ready_n, 1'b0);
    u_host.xfer(1'b0, arr_pkg::ADDR_RESULT, 16'h0000);
    check(rdata, exp_res(1'b0));
    check(ready_n, 1'b1);
    fork
      u_host.xfer(1'b0, arr_pkg::ADDR_RESULT, 16'h0000);
      begin
        @(posedge sys_clk);
        conv(1'b0);
      end
    join
    u_host.xfer(1'b0, arr_pkg::ADDR_RESULT, 16'h0000);
    check(rdata, exp_res(1'b0));
    set_mode(16'h0041);
    check(frame.rd_bytes, exp_len());
    u_host.xfer(1'b0, arr_pkg::ADDR_RESULT, 16'h0000);
    check(rdata, exp_res(1'b1));
    conv(1'b1);
    check(frame.rd_bytes, exp_len());
    u_host.xfer(1'b0, arr_pkg::ADDR_RESULT, 16'h0000);
    check(rdata, exp_res(1'b1));
    user_xor = 24'($random(seed));
    u_host.xfer(1'b0, arr_pkg::ADDR_CHECK, 16'h0000);
    check(rdata, 32'h0000_0000);
    set_mode(16'h0020);
    u_host.xfer(1'b0, arr_pkg::ADDR_CHECK, 16'h0000);
    check(rdata, {8'h00, user_xor});
    user_xor = user_xor ^ 24'h000100;
    repeat (2) @(posedge sys_clk);
    #1 check(integ_fault, 1'b1);
    set_mode(16'h0000);
    repeat (2) @(posedge sys_clk);
    #1 check(integ_fault, 1'b0);
    close_out();
  end
endmodule : test_adc_result_and_integrity_checksum_regs
